// ===== dv/testbench.sv
// Self-checking bench for the auto-wake receiver over AXI4-Lite.
// Assumes the transmitter model on rx_line and the bound checker.
`timescale 1ns/1ps
`include "uawk_map.vh"
module testbench;
    localparam int BAUD = 3;
    localparam int BITC = 16 * (BAUD + 1);
    logic        aclk;
    logic        aresetn;
    logic [3:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    wire         s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    wire         s_axi_wready;
    wire  [1:0]  s_axi_bresp;
    wire         s_axi_bvalid;
    logic        s_axi_bready;
    logic [3:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    wire         s_axi_arready;
    wire  [31:0] s_axi_rdata;
    wire  [1:0]  s_axi_rresp;
    wire         s_axi_rvalid;
    logic        s_axi_rready;
    wire         rx_line;
    wire         rx_irq_flag;
    int          error_cnt;
    int          comparisons;
    int          cyc;
    uawk_rx_wake DUT (.*);
    uawk_tx_model #(.BIT_CYC(BITC)) tx (.aclk(aclk), .rx_line(rx_line));
    task automatic stop_test;
        if (error_cnt == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v,
                      input logic [1:0] er);
        logic aw;
        logic w;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        aw = 1'h1;
        w = 1'h1;
        do begin
            @(posedge aclk);
            if (aw && s_axi_awready) begin
                aw = 1'h0;
                s_axi_awvalid <= 1'h0;
            end
            if (w && s_axi_wready) begin
                w = 1'h0;
                s_axi_wvalid <= 1'h0;
            end
        end while (aw || w);
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        cmp(s_axi_bresp, er);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e,
                       input logic [31:0] m);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        cmp(s_axi_rresp, `UAWK_RESP_OKAY);
        cmp(s_axi_rdata & m, e);
    endtask
    task automatic t_regs;
        rdc(`UAWK_OFF_CTRL, 32'h0, 32'hffffffff);
        rdc(`UAWK_OFF_STATUS, 32'h1, 32'h1f);
        rdc(`UAWK_OFF_BAUD, {16'h0, `UAWK_RST_BAUD}, 32'hffffffff);
        rdc(`UAWK_OFF_DATA, 32'h0, 32'hffffffff);
        // Unmapped write must leave control untouched
        wr(4'h6, 32'h3, `UAWK_RESP_SLVERR);
        rdc(`UAWK_OFF_CTRL, 32'h0, 32'h3);
        wr(`UAWK_OFF_BAUD, BAUD, `UAWK_RESP_OKAY);
        wr(`UAWK_OFF_CTRL, 32'h2, `UAWK_RESP_OKAY);
    endtask
    task automatic t_normal;
        tx.send(8'ha5);
        cmp(rx_irq_flag, 32'h1);
        rdc(`UAWK_OFF_DATA, 32'ha5, 32'hff);
        cmp(rx_irq_flag, 32'h0);
    endtask
    task automatic t_wake;
        rdc(`UAWK_OFF_STATUS, 32'h1, 32'h1);
        wr(`UAWK_OFF_CTRL, 32'h3, `UAWK_RESP_OKAY);
        repeat (BITC) @(posedge aclk);
        cmp(rx_irq_flag, 32'h0);
        rdc(`UAWK_OFF_STATUS, 32'h5, 32'h7);
        fork
            tx.send(8'h00);
            begin
                repeat (BITC) @(posedge aclk);
                cmp(rx_irq_flag, 32'h1);
                rdc(`UAWK_OFF_STATUS, 32'h7, 32'h7);
            end
        join
        rdc(`UAWK_OFF_STATUS, 32'h3, 32'h7);
        rdc(`UAWK_OFF_CTRL, 32'h2, 32'h3);
        rdc(`UAWK_OFF_DATA, 32'h0, 32'hff);
        cmp(rx_irq_flag, 32'h0);
        tx.send(8'h3c);
        rdc(`UAWK_OFF_DATA, 32'h3c, 32'hff);
        // A second character before the read sets overrun and overwrites
        tx.send(8'hc3);
        tx.send(8'h5a);
        rdc(`UAWK_OFF_STATUS, 32'h13, 32'h1f);
        rdc(`UAWK_OFF_DATA, 32'h5a, 32'hff);
        rdc(`UAWK_OFF_STATUS, 32'h1, 32'h1f);
    endtask
    initial begin
        aclk = 1'h0;
        forever #5 aclk = ~aclk;
    end
    // Five frames plus bus traffic fit well inside this ceiling
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test;
        end
    end
    initial begin
        aresetn = 1'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 4'h0;
        s_axi_araddr = 4'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs;
        t_normal;
        t_wake;
        stop_test;
    end
endmodule

// ===== dv/uawk_chk_sva.sv
// Checker for the auto-wake receiver: bus handshakes and flag timing.
// Bound to the receiver top; sees its ports only.
`timescale 1ns/1ps
`include "uawk_map.vh"
module uawk_chk (
    input wire        aclk,          // clock
    input wire        aresetn,       // reset
    input wire [3:0]  s_axi_awaddr,  // aw addr
    input wire        s_axi_awvalid, // aw valid
    input wire        s_axi_awready, // aw ready
    input wire        s_axi_wvalid,  // w valid
    input wire        s_axi_wready,  // w ready
    input wire [1:0]  s_axi_bresp,   // b resp
    input wire        s_axi_bvalid,  // b valid
    input wire        s_axi_bready,  // b ready
    input wire [3:0]  s_axi_araddr,  // ar addr
    input wire        s_axi_arvalid, // ar valid
    input wire        s_axi_arready, // ar ready
    input wire [31:0] s_axi_rdata,   // r data
    input wire [1:0]  s_axi_rresp,   // r resp
    input wire        s_axi_rvalid,  // r valid
    input wire        s_axi_rready,  // r ready
    input wire        rx_line,       // serial in
    input wire        rx_irq_flag    // irq level
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire both_hs = s_axi_awvalid && s_axi_awready
                && s_axi_wvalid && s_axi_wready;
    wire data_rd = s_axi_arvalid && s_axi_arready
                && s_axi_araddr == `UAWK_OFF_DATA;
    chk_write_resp: assert property (both_hs && !s_axi_bvalid
        |-> ##2 s_axi_bvalid) else $error("write response late");
    chk_bad_addr: assert property (both_hs && s_axi_awaddr[1:0] != 2'h0
        |-> ##2 s_axi_bresp == `UAWK_RESP_SLVERR)
        else $error("unmapped write not refused");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    chk_read_resp: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read data late");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken while data pending");
    // Every aligned address of the four-bit map is a register
    chk_read_okay: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rresp == `UAWK_RESP_OKAY)
        else $error("mapped read refused");
    chk_irq_clear: assert property (
        data_rd && rx_irq_flag && rx_line |=> !rx_irq_flag)
        else $error("data read left irq set");
    chk_irq_holds: assert property (
        rx_irq_flag && !data_rd |=> rx_irq_flag)
        else $error("irq lost without data read");
    // Two sync stages stand between the pin and any edge detector
    chk_sync_delay: assert property (
        $fell(rx_line) && !rx_irq_flag |=> !rx_irq_flag [*2])
        else $error("line edge seen unsynchronised");
    cover property ($rose(rx_irq_flag));
    cover property (data_rd && rx_irq_flag);
    cover property (s_axi_bvalid && s_axi_bresp == `UAWK_RESP_SLVERR);
endmodule
bind uawk_rx_wake uawk_chk u_chk (.*);

// ===== dv/uawk_tx_model.sv
// Remote serial transmitter: 8N1 frames, LSB first, line idles high.
// Paced by the receiver clock; bit time in cycles set by parameter.
`timescale 1ns/1ps
module uawk_tx_model #(
    parameter int BIT_CYC = 64
) (
    input wire   aclk,   // clock
    output logic rx_line // serial out
);
    initial rx_line = 1'h1;
    // Caller enters just after a rising edge, so the line moves by NBA
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'h1, b, 1'h0};
        for (int i = 0; i < 10; i++) begin
            rx_line <= f[i];
            repeat (BIT_CYC) @(posedge aclk);
        end
    endtask
endmodule

// ===== rtl/uawk_rx_wake.v
// Serial receiver (8N1, 16x oversampling) with auto-wake-on-edge logic
// and an AXI4-Lite register slave.
// Assumes rx_line is asynchronous to aclk and idles high.
`timescale 1ns/1ps
`include "uawk_map.vh"

module uawk_rx_wake (
    input  wire        aclk,          // System clock, 100 MHz
    input  wire        aresetn,       // Synchronous reset, active low
    input  wire [3:0]  s_axi_awaddr,  // Write address
    input  wire        s_axi_awvalid, // Write address valid
    output wire        s_axi_awready, // Write address ready
    input  wire [31:0] s_axi_wdata,   // Write data
    input  wire [3:0]  s_axi_wstrb,   // Write byte strobes
    input  wire        s_axi_wvalid,  // Write data valid
    output wire        s_axi_wready,  // Write data ready
    output reg  [1:0]  s_axi_bresp,   // Write response
    output reg         s_axi_bvalid,  // Write response valid
    input  wire        s_axi_bready,  // Write response ready
    input  wire [3:0]  s_axi_araddr,  // Read address
    input  wire        s_axi_arvalid, // Read address valid
    output wire        s_axi_arready, // Read address ready
    output reg  [31:0] s_axi_rdata,   // Read data
    output reg  [1:0]  s_axi_rresp,   // Read response
    output reg         s_axi_rvalid,  // Read data valid
    input  wire        s_axi_rready,  // Read data ready
    input  wire        rx_line,       // Serial receive pin
    output wire        rx_irq_flag    // Receive interrupt request level
);

    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_START = 4'b0010;
    localparam [3:0] ST_DATA  = 4'b0100;
    localparam [3:0] ST_STOP  = 4'b1000;

    // Register index from byte address; unmapped gives 3'h4
    function [2:0] reg_index;
        input [3:0] addr;
        begin
            case (addr)
                `UAWK_OFF_CTRL:   reg_index = 3'h0;
                `UAWK_OFF_STATUS: reg_index = 3'h1;
                `UAWK_OFF_DATA:   reg_index = 3'h2;
                `UAWK_OFF_BAUD:   reg_index = 3'h3;
                default:          reg_index = 3'h4;
            endcase
        end
    endfunction

    reg         wake_on_edge_arm;
    reg         rx_enable;
    reg  [15:0] baud_div;
    reg  [7:0]  rx_holding_reg;
    reg         irq_flag;
    reg         ferr_flag;
    reg         ovr_flag;
    reg         wake_seen;

    reg         rx_meta;
    reg         rx_sync;
    reg         rx_prev;

    reg  [15:0] tick_cnt;
    reg         tick;
    reg  [3:0]  state;
    reg  [3:0]  ovs_cnt;
    reg  [2:0]  bit_cnt;
    reg  [7:0]  shift;

    reg         aw_held;
    reg  [3:0]  aw_addr;
    reg         w_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;

    wire        wr_do;
    wire [2:0]  wr_idx;
    wire        rd_do;
    wire [2:0]  rd_idx;
    wire        rx_fall;
    wire        rx_rise;
    wire        wake_evt;
    wire        wake_end;
    wire        char_done;
    wire        char_ok;
    wire        rx_idle_flag;
    wire        data_read;

    assign rx_irq_flag   = irq_flag;
    assign s_axi_awready = ~aw_held;
    assign s_axi_wready  = ~w_held;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_do  = aw_held & w_held & ~s_axi_bvalid;
    assign wr_idx = reg_index(aw_addr);
    assign rd_do  = s_axi_arvalid & ~s_axi_rvalid;
    assign rd_idx = reg_index(s_axi_araddr);
    assign data_read = rd_do & (rd_idx == 3'h2);

    assign rx_fall = rx_prev & ~rx_sync;
    assign rx_rise = ~rx_prev & rx_sync;
    assign wake_evt = wake_on_edge_arm & ~wake_seen & rx_fall;
    assign wake_end = wake_on_edge_arm & wake_seen & rx_rise;

    assign char_done = tick & (state == ST_STOP) &
                       (ovs_cnt == `UAWK_OVS_LAST);
    assign char_ok   = char_done & rx_sync;
    assign rx_idle_flag = (state == ST_IDLE);

    // Two flip-flop synchroniser, then an edge register
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_meta <= rx_line;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    // Oversampling tick divider
    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt <= 16'h0000;
            tick     <= 1'b0;
        end else if (tick_cnt >= baud_div) begin
            tick_cnt <= 16'h0000;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
            tick     <= 1'b0;
        end
    end

    // Character receiver
    always @(posedge aclk) begin
        if (!aresetn) begin
            state   <= ST_IDLE;
            ovs_cnt <= 4'h0;
            bit_cnt <= 3'h0;
            shift   <= 8'h00;
        end else if (wake_on_edge_arm || !rx_enable) begin
            state   <= ST_IDLE;
            ovs_cnt <= 4'h0;
            bit_cnt <= 3'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (!rx_sync) begin
                        state   <= ST_START;
                        ovs_cnt <= 4'h0;
                    end
                end
                ST_START: begin
                    if (tick) begin
                        if (ovs_cnt == `UAWK_OVS_MID) begin
                            ovs_cnt <= 4'h0;
                            bit_cnt <= 3'h0;
                            // Glitch shorter than half a bit is dropped
                            state   <= rx_sync ? ST_IDLE : ST_DATA;
                        end else begin
                            ovs_cnt <= ovs_cnt + 4'h1;
                        end
                    end
                end
                ST_DATA: begin
                    if (tick) begin
                        ovs_cnt <= ovs_cnt + 4'h1;
                        if (ovs_cnt == `UAWK_OVS_LAST) begin
                            shift <= {rx_sync, shift[7:1]};
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == `UAWK_BITS_LAST) begin
                                state <= ST_STOP;
                            end
                        end
                    end
                end
                ST_STOP: begin
                    if (tick) begin
                        ovs_cnt <= ovs_cnt + 4'h1;
                        if (ovs_cnt == `UAWK_OVS_LAST) begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Wake sequencing, flags and holding register
    always @(posedge aclk) begin
        if (!aresetn) begin
            wake_seen      <= 1'b0;
            irq_flag       <= 1'b0;
            ferr_flag      <= 1'b0;
            ovr_flag       <= 1'b0;
            rx_holding_reg <= `UAWK_RST_HOLD;
        end else begin
            if (wake_end || !wake_on_edge_arm) begin
                wake_seen <= 1'b0;
            end else if (wake_evt) begin
                wake_seen <= 1'b1;
            end
            if (wake_evt) begin
                irq_flag       <= 1'b1;
                rx_holding_reg <= `UAWK_DUMMY_CHAR;
            end else if (char_done) begin
                // Stop bit missing still delivers the byte, flagged
                irq_flag       <= 1'b1;
                rx_holding_reg <= shift;
                ferr_flag      <= ~char_ok | (ferr_flag & ~data_read);
                ovr_flag       <= irq_flag & ~data_read | ovr_flag;
            end else if (data_read) begin
                irq_flag  <= 1'b0;
                ferr_flag <= 1'b0;
                ovr_flag  <= 1'b0;
            end
        end
    end

    // AXI write channels: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            aw_addr      <= 4'h0;
            w_held       <= 1'b0;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `UAWK_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_do) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_do) begin
                w_held <= 1'b0;
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_idx == 3'h4) ? `UAWK_RESP_SLVERR
                                                 : `UAWK_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Writable registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            wake_on_edge_arm <= 1'b0;
            rx_enable        <= 1'b0;
            baud_div         <= `UAWK_RST_BAUD;
        end else begin
            if (wr_do && wr_idx == 3'h0 && w_strb[0]) begin
                wake_on_edge_arm <= w_data[`UAWK_CTRL_ARM];
                rx_enable        <= w_data[`UAWK_CTRL_EN];
            end else if (wake_end) begin
                wake_on_edge_arm <= 1'b0;
            end
            if (wr_do && wr_idx == 3'h3) begin
                if (w_strb[0]) begin
                    baud_div[7:0] <= w_data[7:0];
                end
                if (w_strb[1]) begin
                    baud_div[15:8] <= w_data[15:8];
                end
            end
        end
    end

    // AXI read channel; the answer comes one edge after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `UAWK_RESP_OKAY;
        end else if (rd_do) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `UAWK_RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
            case (rd_idx)
                3'h0: begin
                    s_axi_rdata[`UAWK_CTRL_ARM] <= wake_on_edge_arm;
                    s_axi_rdata[`UAWK_CTRL_EN]  <= rx_enable;
                end
                3'h1: begin
                    s_axi_rdata[`UAWK_ST_IDLE] <= rx_idle_flag;
                    s_axi_rdata[`UAWK_ST_IRQ]  <= irq_flag;
                    s_axi_rdata[`UAWK_ST_ARM]  <= wake_on_edge_arm;
                    s_axi_rdata[`UAWK_ST_FERR] <= ferr_flag;
                    s_axi_rdata[`UAWK_ST_OVR]  <= ovr_flag;
                end
                3'h2: begin
                    s_axi_rdata[7:0] <= rx_holding_reg;
                end
                3'h3: begin
                    s_axi_rdata[15:0] <= baud_div;
                end
                default: begin
                    s_axi_rresp <= `UAWK_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ===== shared/uawk_map.vh
// Register map and timing constants of the serial receiver with auto-wake.
// Included by the receiver top; holds definitions only.
`ifndef UAWK_MAP_VH
`define UAWK_MAP_VH

// Register byte offsets (aligned 32-bit words)
`define UAWK_OFF_CTRL    4'h0
`define UAWK_OFF_STATUS  4'h4
`define UAWK_OFF_DATA    4'h8
`define UAWK_OFF_BAUD    4'hc

// Control register fields
`define UAWK_CTRL_ARM    0
`define UAWK_CTRL_EN     1

// Status register fields
`define UAWK_ST_IDLE     0
`define UAWK_ST_IRQ      1
`define UAWK_ST_ARM      2
`define UAWK_ST_FERR     3
`define UAWK_ST_OVR      4

// Reset values and the dummy character loaded on wake
`define UAWK_RST_BAUD    16'h0036
`define UAWK_RST_HOLD    8'h00
`define UAWK_DUMMY_CHAR  8'h00

// Oversampling: last tick of a bit, mid-bit tick, last data bit of a character
`define UAWK_OVS_LAST    4'hf
`define UAWK_OVS_MID     4'h7
`define UAWK_BITS_LAST   3'h7

// AXI4-Lite responses
`define UAWK_RESP_OKAY   2'b00
`define UAWK_RESP_SLVERR 2'b10

`endif
